//--- verilog/rmv_defines.vh
`ifndef RMV_DEFINES_VH
`define RMV_DEFINES_VH

// Mode encoding on the configuration pin and in the mode status bit.
`define RMV_MODE_NORMAL      1'b1
`define RMV_MODE_SPECIAL     1'b0

// Reset vectors.
`define RMV_VEC_RESET        16'hFFFE
`define RMV_VEC_CLKMON       16'hFFFC
`define RMV_VEC_WATCHDOG     16'hFFFA

// Interrupt vector offsets from the vector base.
`define RMV_OFS_UNIMPL       8'hF8
`define RMV_OFS_SWTRAP       8'hF6
`define RMV_OFS_NMI          8'hF4
`define RMV_OFS_SPURIOUS     8'h80
`define RMV_OFS_ACC_OVF      8'hDC
`define RMV_OFS_ACC_EDGE     8'hDA
`define RMV_OFS_WAKEUP       8'h88

// Last count of the wait for the mode synchroniser to fill after reset release.
`define RMV_BOOT_LAST        2'h3

// Reset value of the vector base upper byte.
`define RMV_BASE_RESET       8'hFF

// Watchdog rate field off value; zero disables the watchdog.
`define RMV_WDOG_OFF         3'h0

// Reset source codes.
`define RMV_RST_NONE         3'h0
`define RMV_RST_POWER        3'h1
`define RMV_RST_LOWV         3'h2
`define RMV_RST_PIN          3'h3
`define RMV_RST_ILLEGAL      3'h4
`define RMV_RST_CLKMON       3'h5
`define RMV_RST_WATCHDOG     3'h6

`endif

//--- verilog/rmv_prio_enc.v
`timescale 1ns/100ps
`include "rmv_defines.vh"

// Fixed-priority encoder: bit N-1 has the highest priority.
module rmv_prio_enc #(
   parameter N  = 8,
   parameter IW = 3
) (
   // Request vector
   input  wire [N-1:0]  req_i,
   // Winning index and valid flag
   output reg  [IW-1:0] idx_o,
   output reg           any_o
);

   integer k;

   always @* begin
      idx_o = {IW{1'b0}};
      any_o = 1'b0;
      for (k = 0; k < N; k = k + 1) begin
         if (req_i[k]) begin
            idx_o = k[IW-1:0];
            any_o = 1'b1;
         end
      end
   end

endmodule

//--- verilog/rmv_top.v
// Behaviour
// - Mode pin high selects normal single-chip, low selects special single-chip.
// - Mode pin level is captured into the mode bit once the synchroniser has filled after reset release.
// - Mode bit is readable; running writes permit only restricted mode changes.
// - Special mode: debug active, core runs ROM monitor, waits on background pin.
// - Normal mode: core fetches reset vector and runs from internal memory.
// - Power, low-voltage, pin and illegal-address resets use FFFE, unmaskable.
// - Clock monitor reset uses FFFC, possible only with oscillator enabled.
// - Watchdog reset uses FFFA, enabled by non-zero three-bit rate field.
// - Interrupt vector is vector base plus fixed per-source offset.
// - Pending requests granted in fixed order, trap F8 down to spurious 80.
// - Accumulator overflow uses DC, gated by enable and I, wakes wait only.
// - Accumulator edge uses DA, gated by enable and I, wakes wait only.
// - Periodic wake-up uses 88, gated by enable and I, wakes stop and wait.
// - Selected modules may freeze while background debug is active.
`timescale 1ns/100ps
`include "rmv_defines.vh"

module rmv_top #(
   parameter NSRC = 6,
   parameter IW   = 3
) (
   // Clock and reset
   input  wire        CLK_I,
   input  wire        RST_N_I,
   // Mode configuration pin and mode bit write port
   input  wire        MODE_CONFIG_INPUT_I,
   input  wire        MODE_WR_I,
   input  wire        MODE_WDATA_I,
   // Reset source reporting, one-cycle pulses from the reset logic
   input  wire        RST_POWER_I,
   input  wire        RST_LOWV_I,
   input  wire        RST_PIN_I,
   input  wire        RST_ILLEGAL_I,
   input  wire        RST_CLKMON_I,
   input  wire        RST_WATCHDOG_I,
   input  wire        OSC_ENABLE_BIT_I,
   input  wire [2:0]  WATCHDOG_RATE_FIELD_I,
   // Vector base register write port
   input  wire        BASE_WR_I,
   input  wire [7:0]  BASE_WDATA_I,
   // Condition-code masks from the core
   input  wire        I_MASK_I,
   input  wire        X_MASK_I,
   // Trap and request inputs
   input  wire        UNIMPL_TRAP_I,
   input  wire        SOFTWARE_TRAP_I,
   input  wire        NONMASKABLE_REQUEST_INPUT_I,
   input  wire        ACC_OVF_REQ_I,
   input  wire        ACCUM_OVERFLOW_INT_ENABLE_I,
   input  wire        ACC_EDGE_REQ_I,
   input  wire        ACCUM_EDGE_INT_ENABLE_I,
   input  wire        WAKEUP_REQ_I,
   input  wire        PERIODIC_WAKEUP_INT_ENABLE_I,
   // Low-power state of the core
   input  wire        IN_STOP_I,
   input  wire        IN_WAIT_I,
   // Freeze option and vector fetch handshake
   input  wire        FREEZE_EN_I,
   input  wire        VEC_ACK_I,
   input  wire        RST_FETCH_I,
   // Outputs
   output reg         MODE_BIT_O,
   output reg         DEBUG_ACTIVE_O,
   output reg         ROM_MONITOR_O,
   output reg         BACKGROUND_PIN_CMD_WAIT_O,
   output reg         INTERNAL_FETCH_O,
   output reg  [7:0]  BASE_O,
   output reg  [2:0]  RST_SRC_O,
   output reg  [15:0] RST_VEC_O,
   output wire        IRQ_PENDING_O,
   output reg  [15:0] INT_VEC_O,
   output reg         INT_VEC_VALID_O,
   output reg         WAKE_O,
   output wire        FREEZE_O
);

   // Mode pin synchroniser; the mode is captured once after reset release.
   reg        mode_s1;
   reg        mode_s2;
   reg        mode_s3;
   reg [1:0]  boot_cnt;
   reg        captured;

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_s1 <= 1'b0;
         mode_s2 <= 1'b0;
         mode_s3 <= 1'b0;
      end else begin
         mode_s1 <= MODE_CONFIG_INPUT_I;
         mode_s2 <= mode_s1;
         mode_s3 <= mode_s2;
      end
   end

   // Wait until the synchroniser has filled and its last two stages agree.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         boot_cnt   <= 2'h0;
         captured   <= 1'b0;
         MODE_BIT_O <= `RMV_MODE_SPECIAL;
      end else if (!captured) begin
         if (boot_cnt != `RMV_BOOT_LAST) begin
            boot_cnt <= boot_cnt + 2'h1;
         end else if (mode_s2 == mode_s3) begin
            MODE_BIT_O <= mode_s3;
            captured   <= 1'b1;
         end
      end else if (MODE_WR_I && MODE_BIT_O == `RMV_MODE_SPECIAL) begin
         // Only special to normal is allowed while running; normal is locked.
         MODE_BIT_O <= MODE_WDATA_I;
      end
   end

   // Mode-dependent core behaviour.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         DEBUG_ACTIVE_O   <= 1'b0;
         ROM_MONITOR_O    <= 1'b0;
         BACKGROUND_PIN_CMD_WAIT_O  <= 1'b0;
         INTERNAL_FETCH_O <= 1'b0;
      end else begin
         DEBUG_ACTIVE_O   <= captured && MODE_BIT_O == `RMV_MODE_SPECIAL;
         ROM_MONITOR_O    <= captured && MODE_BIT_O == `RMV_MODE_SPECIAL;
         BACKGROUND_PIN_CMD_WAIT_O  <= captured && MODE_BIT_O == `RMV_MODE_SPECIAL;
         INTERNAL_FETCH_O <= captured && MODE_BIT_O == `RMV_MODE_NORMAL;
      end
   end

   assign FREEZE_O = FREEZE_EN_I & DEBUG_ACTIVE_O;

   // Reset source recording; gated sources are dropped when their enable is off.
   wire clkmon_ok = RST_CLKMON_I & OSC_ENABLE_BIT_I;
   wire wdog_ok   = RST_WATCHDOG_I & (WATCHDOG_RATE_FIELD_I != `RMV_WDOG_OFF);

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RST_SRC_O <= `RMV_RST_NONE;
      end else if (RST_POWER_I) begin
         RST_SRC_O <= `RMV_RST_POWER;
      end else if (RST_LOWV_I) begin
         RST_SRC_O <= `RMV_RST_LOWV;
      end else if (RST_PIN_I) begin
         RST_SRC_O <= `RMV_RST_PIN;
      end else if (RST_ILLEGAL_I) begin
         RST_SRC_O <= `RMV_RST_ILLEGAL;
      end else if (clkmon_ok) begin
         RST_SRC_O <= `RMV_RST_CLKMON;
      end else if (wdog_ok) begin
         RST_SRC_O <= `RMV_RST_WATCHDOG;
      end
   end

   // Reset vector presented whenever the core fetches; unmaskable by design.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RST_VEC_O <= `RMV_VEC_RESET;
      end else if (RST_FETCH_I) begin
         case (RST_SRC_O)
            `RMV_RST_CLKMON:   RST_VEC_O <= `RMV_VEC_CLKMON;
            `RMV_RST_WATCHDOG: RST_VEC_O <= `RMV_VEC_WATCHDOG;
            default:           RST_VEC_O <= `RMV_VEC_RESET;
         endcase
      end
   end

   // Vector base register.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         BASE_O <= `RMV_BASE_RESET;
      end else if (BASE_WR_I) begin
         BASE_O <= BASE_WDATA_I;
      end
   end

   // Request vector, lowest index lowest priority.
   wire [NSRC-1:0] req;
   assign req[5] = UNIMPL_TRAP_I;
   assign req[4] = SOFTWARE_TRAP_I;
   assign req[3] = NONMASKABLE_REQUEST_INPUT_I & ~X_MASK_I;
   assign req[2] = ACC_OVF_REQ_I & ACCUM_OVERFLOW_INT_ENABLE_I & ~I_MASK_I;
   assign req[1] = ACC_EDGE_REQ_I & ACCUM_EDGE_INT_ENABLE_I & ~I_MASK_I;
   assign req[0] = WAKEUP_REQ_I & PERIODIC_WAKEUP_INT_ENABLE_I & ~I_MASK_I;

   wire [IW-1:0] win;
   wire          any;

   rmv_prio_enc #(
      .N  (NSRC),
      .IW (IW)
   ) u_enc (
      .req_i (req),
      .idx_o (win),
      .any_o (any)
   );

   assign IRQ_PENDING_O = any;

   reg [7:0] ofs;
   always @* begin
      case (win)
         3'h5:    ofs = `RMV_OFS_UNIMPL;
         3'h4:    ofs = `RMV_OFS_SWTRAP;
         3'h3:    ofs = `RMV_OFS_NMI;
         3'h2:    ofs = `RMV_OFS_ACC_OVF;
         3'h1:    ofs = `RMV_OFS_ACC_EDGE;
         default: ofs = `RMV_OFS_WAKEUP;
      endcase
      if (!any) begin
         ofs = `RMV_OFS_SPURIOUS;
      end
   end

   // Vector answer one cycle after acknowledge.
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         INT_VEC_O       <= 16'h0000;
         INT_VEC_VALID_O <= 1'b0;
      end else begin
         INT_VEC_VALID_O <= VEC_ACK_I;
         if (VEC_ACK_I) begin
            INT_VEC_O <= {BASE_O, ofs};
         end
      end
   end

   // Wake-up: only the periodic source and the nonmaskable input leave stop.
   wire wake_stop = req[0] | req[3];
   wire wake_wait = req[0] | req[1] | req[2] | req[3];

   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         WAKE_O <= 1'b0;
      end else begin
         WAKE_O <= (IN_STOP_I & wake_stop) | (IN_WAIT_I & wake_wait);
      end
   end

endmodule

//--- testbench/rmv_props.sv
`timescale 1ns/100ps
module rmv_props (
   // Block inputs
   input wire        CLK_I,
   input wire        RST_N_I,
   input wire        VEC_ACK_I,
   input wire        RST_FETCH_I,
   input wire        UNIMPL_TRAP_I,
   input wire        SOFTWARE_TRAP_I,
   input wire        FREEZE_EN_I,
   // Block outputs
   input wire        MODE_BIT_O,
   input wire        DEBUG_ACTIVE_O,
   input wire        FREEZE_O,
   input wire        IRQ_PENDING_O,
   input wire        INT_VEC_VALID_O,
   input wire [7:0]  BASE_O,
   input wire [2:0]  RST_SRC_O,
   input wire [15:0] RST_VEC_O,
   input wire [15:0] INT_VEC_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_ack;
      VEC_ACK_I;
   endsequence
   sequence s_answer;
      INT_VEC_VALID_O && INT_VEC_O[15:8] == $past(BASE_O);
   endsequence
   a_vec_answer: assert property (s_ack |=> s_answer)
      else $error("vector answer late or base wrong");
   a_valid_pulse: assert property (!VEC_ACK_I |=> !INT_VEC_VALID_O)
      else $error("vector valid without acknowledge");
   a_trap_first: assert property (VEC_ACK_I && UNIMPL_TRAP_I |=> INT_VEC_O[7:0] == 8'hF8)
      else $error("trap not granted first");
   a_swtrap_unmasked: assert property (VEC_ACK_I && !UNIMPL_TRAP_I && SOFTWARE_TRAP_I
      |=> INT_VEC_O[7:0] == 8'hF6)
      else $error("software trap not granted");
   a_spurious_vec: assert property (VEC_ACK_I && !IRQ_PENDING_O
      |=> INT_VEC_O[7:0] == 8'h80)
      else $error("spurious vector missing");
   a_reset_vector: assert property (RST_FETCH_I |=> RST_VEC_O == ($past(RST_SRC_O) == 3'h5
      ? 16'hFFFC : $past(RST_SRC_O) == 3'h6 ? 16'hFFFA : 16'hFFFE))
      else $error("reset vector wrong");
   a_freeze_gate: assert property (FREEZE_O == (FREEZE_EN_I && DEBUG_ACTIVE_O))
      else $error("freeze not gated by debug");
   a_normal_lock: assert property (MODE_BIT_O |=> MODE_BIT_O)
      else $error("normal mode left while running");
endmodule

bind rmv_top rmv_props u_props (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .VEC_ACK_I(VEC_ACK_I), .RST_FETCH_I(RST_FETCH_I),
   .UNIMPL_TRAP_I(UNIMPL_TRAP_I), .SOFTWARE_TRAP_I(SOFTWARE_TRAP_I),
   .FREEZE_EN_I(FREEZE_EN_I), .MODE_BIT_O(MODE_BIT_O), .DEBUG_ACTIVE_O(DEBUG_ACTIVE_O),
   .FREEZE_O(FREEZE_O), .IRQ_PENDING_O(IRQ_PENDING_O), .INT_VEC_VALID_O(INT_VEC_VALID_O),
   .BASE_O(BASE_O), .RST_SRC_O(RST_SRC_O), .RST_VEC_O(RST_VEC_O), .INT_VEC_O(INT_VEC_O)
);

//--- testbench/rmv_core_model.sv
`timescale 1ns/100ps
module rmv_core_model (
   input  wire clk_i,
   input  wire rst_n_i,
   input  wire want_vec_i,
   input  wire want_rst_i,
   output reg  ack_o,
   output reg  fetch_o
);
   // Each request is registered and passed on one cycle later, as the core gives.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o   <= 1'b0;
         fetch_o <= 1'b0;
      end else begin
         ack_o   <= want_vec_i;
         fetch_o <= want_rst_i;
      end
   end
endmodule

//--- testbench/reset_mode_vector_select_test.sv
`timescale 1ns/100ps
module reset_mode_vector_select_test;
   reg         clk = 1'b0;
   reg         rst_n, mpin, mwr, mwd, osc, bwr, im, xm, stp, wt, fz, wv, wf;
   reg  [5:0]  rp, rq;
   reg  [2:0]  rate, en;
   reg  [7:0]  bwd;
   reg  [31:0] seed = 32'h0000_005E;
   reg  [15:0] q [$];
   reg  [23:0] t;
   reg  [11:0] w;
   wire        ack, fetch, mbit, dbg, rom, bkw, ifx, vv, wake, fzo;
   wire [15:0] rvec, ivec;
   int         n_fail = 0, check_count = 0, cyc = 0, k;
   localparam [23:0] RTAB [0:7] = '{24'h01_FFFE, 24'h85_FFFC, 24'h02_FFFE, 24'h05_FFFE,
      24'h76_FFFA, 24'h03_FFFE, 24'h06_FFFE, 24'h04_FFFE};
   localparam [11:0] WTAB [0:2] = '{12'h813, 12'h86C, 12'h46D};

   always #25 clk = ~clk;

   rmv_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .want_vec_i(wv), .want_rst_i(wf),
      .ack_o(ack), .fetch_o(fetch));

   rmv_top u_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .MODE_CONFIG_INPUT_I(mpin), .MODE_WR_I(mwr),
      .MODE_WDATA_I(mwd), .RST_POWER_I(rp[0]), .RST_LOWV_I(rp[1]), .RST_PIN_I(rp[2]),
      .RST_ILLEGAL_I(rp[3]), .RST_CLKMON_I(rp[4]), .RST_WATCHDOG_I(rp[5]),
      .OSC_ENABLE_BIT_I(osc), .WATCHDOG_RATE_FIELD_I(rate), .BASE_WR_I(bwr),
      .BASE_WDATA_I(bwd), .I_MASK_I(im), .X_MASK_I(xm), .UNIMPL_TRAP_I(rq[5]),
      .SOFTWARE_TRAP_I(rq[4]), .NONMASKABLE_REQUEST_INPUT_I(rq[3]), .ACC_OVF_REQ_I(rq[2]),
      .ACCUM_OVERFLOW_INT_ENABLE_I(en[2]), .ACC_EDGE_REQ_I(rq[1]),
      .ACCUM_EDGE_INT_ENABLE_I(en[1]), .WAKEUP_REQ_I(rq[0]),
      .PERIODIC_WAKEUP_INT_ENABLE_I(en[0]), .IN_STOP_I(stp), .IN_WAIT_I(wt),
      .FREEZE_EN_I(fz), .VEC_ACK_I(ack), .RST_FETCH_I(fetch), .MODE_BIT_O(mbit),
      .DEBUG_ACTIVE_O(dbg), .ROM_MONITOR_O(rom), .BACKGROUND_PIN_CMD_WAIT_O(bkw),
      .INTERNAL_FETCH_O(ifx), .BASE_O(), .RST_SRC_O(), .RST_VEC_O(rvec),
      .IRQ_PENDING_O(), .INT_VEC_O(ivec), .INT_VEC_VALID_O(vv), .WAKE_O(wake),
      .FREEZE_O(fzo));

   function [31:0] xs(input [31:0] v);
      reg [31:0] s;
      begin
         s = v ^ (v << 13);
         s = s ^ (s >> 17);
         xs = s ^ (s << 5);
      end
   endfunction

   // Request bits run trap, software trap, nonmaskable, overflow, edge, wake-up.
   function [7:0] ofs(input [5:0] r, input [2:0] e, input i, input x);
      if (r[5]) ofs = 8'hF8;
      else if (r[4]) ofs = 8'hF6;
      else if (r[3] && !x) ofs = 8'hF4;
      else if (!i && r[2] && e[2]) ofs = 8'hDC;
      else if (!i && r[1] && e[1]) ofs = 8'hDA;
      else if (!i && r[0] && e[0]) ofs = 8'h88;
      else ofs = 8'h80;
   endfunction

   task cmp(input [15:0] got, input [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wmode(input v);
      @(posedge clk);
      mwr <= 1'b1;
      mwd <= v;
      @(posedge clk);
      mwr <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task report_and_stop;
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk) begin
      if (vv === 1'b1) cmp(ivec, q.size() ? q.pop_front() : 16'hxxxx);
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop;
      end
   end

   initial begin
      {mwr, mwd, osc, bwr, im, xm, stp, wt, wv, wf, rp, rq, rate, en, bwd} = 0;
      {rst_n, mpin, fz} = 3'b001;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      cmp(mbit, 16'h0000);
      cmp({dbg, rom, bkw, ifx, fzo}, 16'h001D);
      wmode(1'b1);
      cmp({mbit, ifx, dbg}, 16'h0006);
      wmode(1'b0);
      cmp(mbit, 16'h0001);
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         seed = xs(seed);
         rq <= seed[5:0] & seed[11:6];
         {en, im, xm, bwd} <= {seed[14:12], seed[15] & seed[16], seed[17], seed[25:18]};
         bwr <= 1'b1;
         @(posedge clk);
         bwr <= 1'b0;
         wv <= 1'b1;
         q.push_back({bwd, ofs(rq, en, im, xm)});
         @(posedge clk);
         wv <= 1'b0;
         repeat (3) @(posedge clk);
      end
      for (k = 0; k < 8; k++) begin
         t = RTAB[k];
         @(posedge clk);
         {osc, rate} <= t[23:20];
         @(posedge clk);
         rp <= 6'h01 << (t[19:16] - 4'h1);
         @(posedge clk);
         rp <= 6'h00;
         wf <= 1'b1;
         @(posedge clk);
         wf <= 1'b0;
         repeat (3) @(posedge clk);
         cmp(rvec, t[15:0]);
      end
      for (k = 0; k < 3; k++) begin
         w = WTAB[k];
         @(posedge clk);
         {stp, wt, rq, en, im, xm} <= {w[11:1], 2'b01};
         repeat (3) @(posedge clk);
         cmp(wake, {15'h0000, w[0]});
      end
      report_and_stop;
   end
endmodule
